// >>> hw/cfg_pins_consts.svh
// Constants for the configuration port pin control block.
`ifndef CFG_PINS_CONSTS_SVH
`define CFG_PINS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Mode select codes and strap values
// ----------------------------------------------------------------------------
`define MODE_SERIAL_FLASH    3'h1
`define MODE_PAR_FLASH_UP    3'h2
`define MODE_PAR_FLASH_DOWN  3'h3
`define MODE_SLAVE_PARALLEL  3'h6
`define FVS_READ_CMD_STRAP   3'h1

// ----------------------------------------------------------------------------
// Pin field positions and widths
// ----------------------------------------------------------------------------
`define BUS_W                32
`define DATA_PIN_W           16
`define ADDR_PIN_W           26
`define ADDR_LOW_W           16
`define RCMD_W               8
`define FVS_W                3
`define REV_W                2
`define REV_FORCED           2'h0
`define ADDR_ALL_ON          26'h3ffffff
`define ADDR_LOW_ON          26'h000ffff
`define ADDR_ALL_OFF         26'h0000000

`endif

// >>> hw/cfg_pins_pkg.sv
// Types shared by the configuration port pin control block.
package cfg_pins_pkg;
`include "cfg_pins_consts.svh"

  typedef enum logic [2:0] {
    MODE_SERIAL_FLASH   = `MODE_SERIAL_FLASH,
    MODE_PAR_FLASH_UP   = `MODE_PAR_FLASH_UP,
    MODE_PAR_FLASH_DOWN = `MODE_PAR_FLASH_DOWN,
    MODE_SLAVE_PARALLEL = `MODE_SLAVE_PARALLEL
  } config_mode_t;

  typedef enum logic [0:0] {
    ST_WAIT_INIT = 1'b0,
    ST_ACTIVE    = 1'b1
  } ctl_state_t;

  typedef struct packed {
    logic flash_select_n;
    logic flash_output_enable_n;
    logic flash_write_enable_n;
    logic downstream_select_n;
  } flash_pins_t;

  typedef struct packed {
    logic                select;
    logic                read;
    logic                write;
    logic                serial_data;
    logic                downstream_select;
    logic [`ADDR_PIN_W-1:0] addr;
  } flash_req_t;
endpackage

// >>> hw/word_buffer2.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/100ps
module word_buffer2
  import cfg_pins_pkg::*;
#(
  parameter int WIDTH = 32
)(
  // Clock, reset and enable
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  // Filling side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Draining side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  if (WIDTH < 1) begin : g_chk
    $error("word_buffer2 needs WIDTH of at least one");
  end

  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic                  wptr;
    logic                  rptr;
    logic [1:0]            count;
  } buf_state_t;

  buf_state_t s_q;
  buf_state_t s_d;
  logic       push;
  logic       pop;

  always_comb
  begin
    s_d  = s_q;
    push = in_valid_i && (s_q.count != 2'h2);
    pop  = out_ready_i && (s_q.count != 2'h0);
    if (push)
    begin
      s_d.mem[s_q.wptr] = in_data_i;
      s_d.wptr          = ~s_q.wptr;
    end
    if (pop)
    begin
      s_d.rptr = ~s_q.rptr;
    end
    if (push && !pop)
    begin
      s_d.count = s_q.count + 2'h1;
    end
    else if (pop && !push)
    begin
      s_d.count = s_q.count - 2'h1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else if (ce_i)
    begin
      s_q <= s_d;
    end
  end

  assign in_ready_o  = (s_q.count != 2'h2);
  assign out_valid_o = (s_q.count != 2'h0);
  assign out_data_o  = s_q.mem[s_q.rptr];
endmodule

// >>> hw/config_port_pin_control.sv
// Mode-dependent control of the shared configuration pins.
//
// Functional notes
// - Parallel data bus enabled while port select low, disabled while high.
// - Direction low means pins are write inputs; high means pins driven for reads.
// - Direction change while selected raises the abort condition.
// - Program reset leaves the boundary-scan state machine untouched.
// - Error or watchdog forces both revision selects to zero, except slave parallel.
// - Variant select 001 straps read command from low address pins at init rise.
// - Serial-flash mode reads variant select from the three lowest data pins.
// - Slave parallel uses low sixteen address pins as data bits 31 to 16.
// - Parallel-flash mode drives the full 26-bit flash address.
// - One active-low flash select serves parallel and serial flash modes.
// - Parallel flash drives output and write enables; serial flash sends data.
// - Active-low downstream select drives the next chained device.
// - Low data pins are inputs in parallel flash, bidirectional in slave parallel.
// - Mode select inputs are sampled on the init status rising edge.
// - Program input acts as asynchronous reset of the whole block.
// - Slave parallel drives busy on the shared pin; serial modes drive serial out.
`timescale 1ns/100ps
`include "cfg_pins_consts.svh"
module config_port_pin_control
  import cfg_pins_pkg::*;
#(
  parameter int BUS_WIDTH = `BUS_W
)(
  // Clock, program reset and enable
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  // Strap and status inputs
  input  wire logic [2:0]              mode_i,
  input  wire logic                    init_status_i,
  input  wire logic                    config_error_i,
  input  wire logic                    watchdog_event_i,
  // Slave parallel port control
  input  wire logic                    port_select_n_i,
  input  wire logic                    port_direction_i,
  // Shared data and address pins
  input  wire logic [`DATA_PIN_W-1:0]  data_pin_i,
  output logic [`DATA_PIN_W-1:0]       data_pin_o,
  output logic                         data_pin_oe_o,
  input  wire logic [`ADDR_LOW_W-1:0]  addr_pin_i,
  output logic [`ADDR_PIN_W-1:0]       addr_pin_o,
  output logic [`ADDR_PIN_W-1:0]       addr_pin_oe_o,
  // Flash control and chain pins
  output flash_pins_t                  flash_pins_o,
  output logic [`REV_W-1:0]            revision_select_o,
  output logic                         revision_select_oe_o,
  output logic                         busy_serial_out_o,
  output logic                         abort_o,
  // Configuration engine side
  input  flash_req_t                   flash_req_i,
  input  wire logic                    flash_data_strobe_i,
  input  wire logic [`REV_W-1:0]       revision_i,
  input  wire logic                    serial_out_i,
  output config_mode_t                 mode_o,
  output logic                         active_o,
  output logic [`RCMD_W-1:0]           flash_read_command_strap_o,
  output logic [`FVS_W-1:0]            flash_variant_select_o,
  output logic                         wr_valid_o,
  output logic [BUS_WIDTH-1:0]         wr_data_o,
  input  wire logic                    wr_ready_i,
  input  wire logic                    rd_valid_i,
  input  wire logic [BUS_WIDTH-1:0]    rd_data_i,
  output logic                         rd_ready_o
);
  if (BUS_WIDTH != `BUS_W) begin : g_chk
    $error("config_port_pin_control serves only a 32-bit configuration bus");
  end

  typedef struct packed {
    ctl_state_t                st;
    config_mode_t              mode;
    logic [`RCMD_W-1:0]        rcmd;
    logic [`FVS_W-1:0]         fvs;
    logic                      init_prev;
    logic [1:0]                sel_sync;
    logic [1:0]                dir_sync;
    logic                      dir_prev;
    logic [`BUS_W-1:0]         bus_s1;
    logic [`BUS_W-1:0]         bus_s2;
    logic                      abort;
    logic                      rs_forced;
    logic [`REV_W-1:0]         rs;
    logic                      rs_oe;
    logic [`DATA_PIN_W-1:0]    d_out;
    logic                      d_oe;
    logic [`ADDR_PIN_W-1:0]    a_out;
    logic [`ADDR_PIN_W-1:0]    a_oe;
    flash_pins_t               flash;
    logic                      busy_serial;
    logic                      rd_ready;
  } ctl_reg_t;

  localparam ctl_reg_t RESET_VAL = '{
    st: ST_WAIT_INIT, mode: MODE_SERIAL_FLASH, flash: 4'hf,
    sel_sync: 2'h3, default: '0};

  ctl_reg_t          s_q;
  ctl_reg_t          s_d;
  logic              buf_in_valid;
  logic [`BUS_W-1:0] buf_in_data;
  logic              buf_in_ready;

  function automatic logic is_par_flash(input config_mode_t m);
    return (m == MODE_PAR_FLASH_UP) || (m == MODE_PAR_FLASH_DOWN);
  endfunction

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  logic selected;
  logic dir_change;
  logic slave_on;
  logic pflash_on;
  logic sflash_on;

  always_comb
  begin
    s_d          = s_q;
    buf_in_valid = 1'b0;
    buf_in_data  = s_q.bus_s2;
    // The first stages are read only by the second stages.
    s_d.sel_sync = {s_q.sel_sync[0], port_select_n_i};
    s_d.dir_sync = {s_q.dir_sync[0], port_direction_i};
    s_d.bus_s1   = {addr_pin_i, data_pin_i};
    s_d.bus_s2   = s_q.bus_s1;
    s_d.dir_prev = s_q.dir_sync[1];
    s_d.init_prev = init_status_i;
    selected   = !s_q.sel_sync[1];
    dir_change = s_q.dir_sync[1] != s_q.dir_prev;
    slave_on   = (s_q.st == ST_ACTIVE) && (s_q.mode == MODE_SLAVE_PARALLEL);
    pflash_on  = (s_q.st == ST_ACTIVE) && is_par_flash(s_q.mode);
    sflash_on  = (s_q.st == ST_ACTIVE) && (s_q.mode == MODE_SERIAL_FLASH);
    case (s_q.st)
      ST_WAIT_INIT:
      begin
        if (init_status_i && !s_q.init_prev)
        begin
          s_d.mode = config_mode_t'(mode_i);
          s_d.st   = ST_ACTIVE;
          if (mode_i == `MODE_SERIAL_FLASH)
          begin
            s_d.fvs = data_pin_i[`FVS_W-1:0];
            if (data_pin_i[`FVS_W-1:0] == `FVS_READ_CMD_STRAP)
            begin
              s_d.rcmd = addr_pin_i[`RCMD_W-1:0];
            end
          end
        end
      end
      ST_ACTIVE:
      begin
        s_d.st = ST_ACTIVE;
      end
      default:
      begin
        s_d.st = ST_WAIT_INIT;
      end
    endcase
    // Abort holds until the port is deselected.
    if (!selected)
    begin
      s_d.abort = 1'b0;
    end
    else if (slave_on && dir_change)
    begin
      s_d.abort = 1'b1;
    end
    // Write words from the port, or read data from parallel flash, enter the buffer.
    if (slave_on && selected && !s_q.dir_sync[1] && !dir_change && !s_q.abort)
    begin
      buf_in_valid = 1'b1;
    end
    else if (pflash_on && flash_data_strobe_i)
    begin
      buf_in_valid = 1'b1;
      buf_in_data  = {{(`BUS_W-`DATA_PIN_W){1'b0}}, data_pin_i};
    end
    // Read words are driven onto both pin groups.
    s_d.rd_ready = slave_on && selected && s_q.dir_sync[1] && !s_q.abort && !dir_change;
    if (rd_valid_i && s_q.rd_ready)
    begin
      s_d.d_out = rd_data_i[`DATA_PIN_W-1:0];
      s_d.a_out = {{(`ADDR_PIN_W-`ADDR_LOW_W){1'b0}}, rd_data_i[`BUS_W-1:`DATA_PIN_W]};
    end
    s_d.d_oe = slave_on && selected && s_q.dir_sync[1] && !s_q.abort;
    s_d.a_oe = `ADDR_ALL_OFF;
    s_d.flash = 4'hf;
    s_d.busy_serial = serial_out_i;
    if (slave_on)
    begin
      s_d.a_oe = s_d.d_oe ? `ADDR_LOW_ON : `ADDR_ALL_OFF;
      s_d.busy_serial = !buf_in_ready;
      s_d.flash.downstream_select_n = !flash_req_i.downstream_select;
    end
    else if (pflash_on)
    begin
      s_d.a_out = flash_req_i.addr;
      s_d.a_oe  = `ADDR_ALL_ON;
      s_d.flash.flash_select_n        = !flash_req_i.select;
      s_d.flash.flash_output_enable_n = !flash_req_i.read;
      s_d.flash.flash_write_enable_n  = !flash_req_i.write;
      s_d.flash.downstream_select_n   = !flash_req_i.downstream_select;
    end
    else if (sflash_on)
    begin
      s_d.flash.flash_select_n        = !flash_req_i.select;
      s_d.flash.flash_output_enable_n = flash_req_i.serial_data;
    end
    // Error and watchdog events outside slave parallel mode pull both revision selects low and keep them there.
    if ((s_q.st == ST_ACTIVE) && (s_q.mode != MODE_SLAVE_PARALLEL)
        && (config_error_i || watchdog_event_i))
    begin
      s_d.rs_forced = 1'b1;
    end
    s_d.rs    = s_d.rs_forced ? `REV_FORCED : revision_i;
    s_d.rs_oe = s_d.rs_forced || pflash_on;
  end

  // Program reset clears only this block; no boundary-scan state lives here.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= RESET_VAL;
    end
    else if (ce_i)
    begin
      s_q <= s_d;
    end
  end

  word_buffer2 #(.WIDTH(`BUS_W)) u_buf (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .in_valid_i (buf_in_valid),
    .in_data_i  (buf_in_data),
    .in_ready_o (buf_in_ready),
    .out_valid_o(wr_valid_o),
    .out_data_o (wr_data_o),
    .out_ready_i(wr_ready_i)
  );

  assign data_pin_o                 = s_q.d_out;
  assign data_pin_oe_o              = s_q.d_oe;
  assign addr_pin_o                 = s_q.a_out;
  assign addr_pin_oe_o              = s_q.a_oe;
  assign flash_pins_o               = s_q.flash;
  assign revision_select_o          = s_q.rs;
  assign revision_select_oe_o       = s_q.rs_oe;
  assign busy_serial_out_o          = s_q.busy_serial;
  assign abort_o                    = s_q.abort;
  assign mode_o                     = s_q.mode;
  assign active_o                   = (s_q.st == ST_ACTIVE);
  assign flash_read_command_strap_o = s_q.rcmd;
  assign flash_variant_select_o     = s_q.fvs;
  assign rd_ready_o                 = s_q.rd_ready;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  bus_disabled_a: assert property (ce_i && s_q.sel_sync[1] |=> !data_pin_oe_o)
    else $error("data bus driven while port deselected");
  read_direction_a: assert property (ce_i && data_pin_oe_o |-> $past(s_q.dir_sync[1]))
    else $error("data bus driven during write direction");
  abort_raise_a: assert property (ce_i && slave_on && selected && dir_change |=> abort_o)
    else $error("direction change while selected gave no abort");
  rev_forced_a: assert property (ce_i && active_o && mode_o != MODE_SLAVE_PARALLEL
      && (config_error_i || watchdog_event_i)
      |=> revision_select_o == `REV_FORCED && revision_select_oe_o)
    else $error("revision selects not forced low");
  cmd_strap_a: assert property (ce_i && !active_o && init_status_i && !s_q.init_prev
      && mode_i == `MODE_SERIAL_FLASH && data_pin_i[2:0] == `FVS_READ_CMD_STRAP
      |=> flash_read_command_strap_o == $past(addr_pin_i[7:0]))
    else $error("read command strap not captured");
  variant_strap_a: assert property (ce_i && !active_o && init_status_i && !s_q.init_prev
      && mode_i == `MODE_SERIAL_FLASH |=> flash_variant_select_o == $past(data_pin_i[2:0]))
    else $error("variant select not captured");
  mode_latch_a: assert property (ce_i && !active_o && init_status_i && !s_q.init_prev
      |=> active_o && mode_o == $past(mode_i))
    else $error("mode not latched on init rise");
  flash_addr_a: assert property (ce_i && pflash_on
      |=> addr_pin_o == $past(flash_req_i.addr) && addr_pin_oe_o == `ADDR_ALL_ON)
    else $error("flash address not driven");
  serial_we_a: assert property (ce_i && sflash_on |=> flash_pins_o.flash_write_enable_n)
    else $error("write enable active in serial flash mode");
  busy_pin_a: assert property (ce_i && slave_on |=> busy_serial_out_o == $past(!buf_in_ready))
    else $error("busy pin does not follow buffer");
  sync_delay_a: assert property (ce_i ##1 ce_i |=> s_q.sel_sync[1] == $past(port_select_n_i, 2))
    else $error("port select not synchronised");

  abort_seen_c: cover property (slave_on && dir_change && selected ##1 abort_o);
  write_word_c: cover property (buf_in_valid && buf_in_ready && slave_on);
  read_word_c:  cover property (rd_valid_i && rd_ready_o);
  rev_force_c:  cover property (!s_q.rs_forced ##1 s_q.rs_forced);
endmodule

// >>> test/flash_model.sv
// Behavioural parallel flash that answers reads on the shared data pins.
`timescale 1ns/100ps
module flash_model
  import cfg_pins_pkg::*;
(
  // Clock
  input  wire logic        clk_i,
  // Flash address and control from the device
  input  wire logic [25:0] addr_i,
  input  flash_pins_t      pins_i,
  // Flash data toward the device
  output logic [15:0]      data_o
);
  logic [15:0] last_q = 16'h0;
  logic        drive;

  // The flash drives only while selected and output-enabled; released lines wander.
  assign drive  = !pins_i.flash_select_n && !pins_i.flash_output_enable_n;
  assign data_o = drive ? (addr_i[15:0] ^ 16'ha5c3) : ~last_q;

  always @(posedge clk_i)
  begin
    last_q <= data_o;
  end
endmodule

// >>> test/testbench.sv
// Self-checking bench for the configuration pin control block.
`timescale 1ns/100ps
module testbench
  import cfg_pins_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, init_status_i = 1'b0;
  logic config_error_i = 1'b0, watchdog_event_i = 1'b0, flash_data_strobe_i = 1'b0;
  logic port_select_n_i = 1'b1, port_direction_i = 1'b0, par_mode = 1'b0;
  logic serial_out_i = 1'b0, wr_ready_i = 1'b1, rd_valid_i = 1'b0;
  logic [2:0]  mode_i = 3'h0;
  logic [1:0]  revision_i = 2'h0;
  logic [15:0] tb_data = 16'h0, tb_addr = 16'h0, data_pin_i, addr_pin_i, data_pin_o, fl_data;
  logic [31:0] rd_data_i = 32'h0, wr_data_o, r;
  logic [25:0] addr_pin_o, addr_pin_oe_o;
  logic [7:0]  rcmd;
  logic [2:0]  fvs;
  logic [1:0]  revision_select_o;
  logic        data_pin_oe_o, revision_select_oe_o, busy_serial_out_o, abort_o;
  logic        active_o, wr_valid_o, rd_ready_o;
  flash_req_t   flash_req_i = '0;
  flash_pins_t  flash_pins_o;
  config_mode_t mode_o;
  logic [31:0] exp_q[$];
  int          seed = 32'h2991, miscompares = 0, compares = 0, i, m;

  always #4 clk_i = ~clk_i;

  // Each shared pin carries the device's value while it drives, else the far side's.
  assign data_pin_i = data_pin_oe_o ? data_pin_o : (par_mode ? fl_data : tb_data);
  assign addr_pin_i = (addr_pin_oe_o[15:0] & addr_pin_o[15:0]) | (~addr_pin_oe_o[15:0] & tb_addr);

  config_port_pin_control dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .mode_i(mode_i),
    .init_status_i(init_status_i), .config_error_i(config_error_i),
    .watchdog_event_i(watchdog_event_i), .port_select_n_i(port_select_n_i),
    .port_direction_i(port_direction_i), .data_pin_i(data_pin_i), .data_pin_o(data_pin_o),
    .data_pin_oe_o(data_pin_oe_o), .addr_pin_i(addr_pin_i), .addr_pin_o(addr_pin_o),
    .addr_pin_oe_o(addr_pin_oe_o), .flash_pins_o(flash_pins_o),
    .revision_select_o(revision_select_o), .revision_select_oe_o(revision_select_oe_o),
    .busy_serial_out_o(busy_serial_out_o), .abort_o(abort_o), .flash_req_i(flash_req_i),
    .flash_data_strobe_i(flash_data_strobe_i), .revision_i(revision_i),
    .serial_out_i(serial_out_i), .mode_o(mode_o), .active_o(active_o),
    .flash_read_command_strap_o(rcmd), .flash_variant_select_o(fvs),
    .wr_valid_o(wr_valid_o), .wr_data_o(wr_data_o), .wr_ready_i(wr_ready_i),
    .rd_valid_i(rd_valid_i), .rd_data_i(rd_data_i), .rd_ready_o(rd_ready_o));

  flash_model flash (.clk_i(clk_i), .addr_i(addr_pin_o), .pins_i(flash_pins_o), .data_o(fl_data));

  task automatic give_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got);
    logic [31:0] exp;
    exp = (exp_q.size() == 0) ? 32'hx : exp_q.pop_front();
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t stream word %h want %h", $time, got, exp);
    end
  endtask

  function automatic bit cond(input int which);
    case (which)
      0: return active_o === 1'b1;
      1: return rd_ready_o === 1'b1;
      2: return abort_o === 1'b1;
      3: return abort_o === 1'b0;
      default: return exp_q.size() == 0;
    endcase
  endfunction

  task automatic wait_for(input int which);
    int n;
    n = 0;
    while (!cond(which) && n < 40)
    begin
      @(negedge clk_i);
      n++;
    end
    if (!cond(which))
    begin
      miscompares++;
      $display("BAD %0t wait %0d ran out", $time, which);
      give_verdict();
    end
  endtask

  task automatic strap(input logic [2:0] md, input logic [15:0] d, input logic [15:0] a);
    @(posedge clk_i);
    rst_i <= 1'b1;
    init_status_i <= 1'b0;
    mode_i <= md;
    tb_data <= d;
    tb_addr <= a;
    par_mode <= (md == 3'h2 || md == 3'h3);
    port_select_n_i <= 1'b1;
    port_direction_i <= 1'b0;
    flash_req_i <= '0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk({active_o, flash_pins_o, abort_o, addr_pin_oe_o}, {1'b0, 4'hf, 27'h0}, "reset");
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    init_status_i <= 1'b1;
    wait_for(0);
    chk(mode_o, md, "mode");
  endtask

  task automatic pulse_event(input bit wd);
    @(posedge clk_i);
    config_error_i <= !wd;
    watchdog_event_i <= wd;
    @(posedge clk_i);
    config_error_i <= 1'b0;
    watchdog_event_i <= 1'b0;
    revision_i <= 2'h3;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic sm_write(input int n, input bit stall);
    @(posedge clk_i);
    wr_ready_i <= !stall;
    for (i = 0; i < n; i++)
    begin
      r = $random(seed);
      port_select_n_i <= 1'b0;
      tb_data <= r[15:0];
      tb_addr <= r[31:16];
      exp_q.push_back(r);
      @(posedge clk_i);
    end
    port_select_n_i <= 1'b1;
    if (stall)
    begin
      repeat (6) @(posedge clk_i);
      @(negedge clk_i);
      chk({busy_serial_out_o, wr_valid_o, data_pin_oe_o}, 3'h6, "full buffer");
      @(posedge clk_i);
      wr_ready_i <= 1'b1;
    end
    wait_for(4);
  endtask

  always @(posedge clk_i)
    if (!rst_i && wr_valid_o === 1'b1 && wr_ready_i === 1'b1)
      chk_word(wr_data_o);

  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    $display("BAD %0t run did not finish", $time);
    give_verdict();
  end

  initial
  begin
    strap(3'h1, 16'h0001, 16'h00c7);
    chk({fvs, rcmd}, {3'h1, 8'hc7}, "straps");
    @(posedge clk_i);
    init_status_i <= 1'b0;
    mode_i <= 3'h6;
    @(posedge clk_i);
    init_status_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk(mode_o, 3'h1, "mode held");
    @(posedge clk_i);
    ce_i <= 1'b0;
    flash_req_i.select <= 1'b1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk(flash_pins_o, 4'hb, "frozen by enable");
    @(posedge clk_i);
    ce_i <= 1'b1;
    for (m = 0; m < 6; m++)
    begin
      @(posedge clk_i);
      r = $random(seed);
      flash_req_i.select <= r[0];
      flash_req_i.serial_data <= r[1];
      serial_out_i <= r[2];
      @(posedge clk_i);
      @(negedge clk_i);
      chk(flash_pins_o[3:1], {~r[0], r[1], 1'b1}, "serial pins");
      chk({busy_serial_out_o, data_pin_oe_o}, {r[2], 1'b0}, "serial out");
    end
    pulse_event(1'b1);
    chk({revision_select_oe_o, revision_select_o}, 3'h4, "forced rs");
    strap(3'h1, 16'h0002, 16'h00c7);
    chk({fvs, rcmd}, {3'h2, 8'h00}, "no command strap");
    strap(3'h0, 16'h0, 16'h0);
    @(posedge clk_i);
    @(negedge clk_i);
    chk({data_pin_oe_o, addr_pin_oe_o}, 27'h0, "unused mode");
    for (m = 2; m < 4; m++)
    begin
      strap(m[2:0], 16'h0, 16'h0);
      for (i = 0; i < 4; i++)
      begin
        @(posedge clk_i);
        r = $random(seed);
        flash_req_i <= {1'b1, 1'b1, r[26], 1'b0, r[27], r[25:0]};
        revision_i <= r[29:28];
        @(posedge clk_i);
        @(negedge clk_i);
        chk({6'h0, addr_pin_oe_o}, 32'h3ffffff, "flash address enable");
        chk({6'h0, addr_pin_o}, {6'h0, r[25:0]}, "flash address");
        chk(flash_pins_o, {2'h0, ~r[26], ~r[27]}, "flash pins");
        chk({revision_select_oe_o, revision_select_o}, {1'b1, r[29:28]}, "rs");
        @(posedge clk_i);
        flash_data_strobe_i <= 1'b1;
        exp_q.push_back({16'h0, r[15:0] ^ 16'ha5c3});
        @(posedge clk_i);
        flash_data_strobe_i <= 1'b0;
      end
      wait_for(4);
      pulse_event(1'b0);
      chk({revision_select_oe_o, revision_select_o}, 3'h4, "forced rs");
    end
    strap(3'h6, 16'h0, 16'h0);
    pulse_event(1'b0);
    chk({revision_select_oe_o, revision_select_o}, 3'h3, "slave rs");
    sm_write(2, 1'b1);
    sm_write(6, 1'b0);
    @(posedge clk_i);
    port_direction_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    port_select_n_i <= 1'b0;
    wait_for(1);
    for (i = 0; i < 3; i++)
    begin
      @(posedge clk_i);
      r = $random(seed);
      rd_valid_i <= 1'b1;
      rd_data_i <= r;
      @(posedge clk_i);
      rd_valid_i <= 1'b0;
      @(negedge clk_i);
      chk({addr_pin_o[15:0], data_pin_o}, r, "read word");
      chk({data_pin_oe_o, addr_pin_oe_o[15:0]}, 17'h1ffff, "read drive");
    end
    @(posedge clk_i);
    port_direction_i <= 1'b0;
    wait_for(2);
    chk(abort_o, 1'b1, "abort");
    @(posedge clk_i);
    port_select_n_i <= 1'b1;
    wait_for(3);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk({abort_o, data_pin_oe_o}, 2'h0, "deselected");
    wait_for(4);
    give_verdict();
  end
endmodule
